// File: common/rx_irq_pkg.sv
// Constants, types and register map for the receiver flag and pin routing block.
// Assumes a single 20 MHz clock and a 32-bit APB register port.
package rx_irq_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0] IDX_PIN_ROUTE_A = 8'h25;
  localparam logic [7:0] IDX_PIN_ROUTE_B_CLOCK_OUT = 8'h26;
  localparam logic [7:0] IDX_EVENT_FLAGS_A = 8'h27;
  localparam logic [7:0] IDX_EVENT_FLAGS_B = 8'h28;
  localparam logic [7:0] IDX_STRENGTH_THRESHOLD = 8'h29;
  localparam logic [7:0] IDX_RX_START_TIMEOUT = 8'h2A;
  localparam logic [7:0] IDX_STRENGTH_TO_PAYLOAD_TIMEOUT = 8'h2B;
  localparam int ADDR_W = 12;
  localparam logic [1:0] WORD_SHIFT = 2'h2;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_MODE_READY = 7;
  localparam int BIT_RX_READY = 6;
  localparam int BIT_LOCK = 4;
  localparam int BIT_STRENGTH = 3;
  localparam int BIT_TIMEOUT = 2;
  localparam int BIT_AUTO = 1;
  localparam int BIT_MATCH = 0;
  localparam int BIT_FULL = 7;
  localparam int BIT_NONEMPTY = 6;
  localparam int BIT_LEVEL = 5;
  localparam int BIT_OVERRUN = 4;
  localparam int BIT_PACKET_DONE = 2;
  localparam int BIT_CRC_GOOD = 1;
  localparam int BIT_SUPPLY_LOW = 0;
  localparam int REF_SEL_LSB = 0;
  localparam int REF_SEL_W = 3;

  // ----------------------------------------
  // Reset values, codes, timeout scale and sizes
  // ----------------------------------------
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [2:0] REF_OFF = 3'h7;
  localparam logic [2:0] REF_RC = 3'h6;
  localparam logic [2:0] REF_DIV_MAX = 3'h5;
  localparam logic [7:0] RST_THRESHOLD = 8'hE4;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam int TIMEOUT_SCALE = 16;
  localparam int QUEUE_BYTES = 66;
  localparam int NUM_PINS = 6;

  typedef enum logic [2:0] {
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_SYNTH,
    MODE_TX,
    MODE_RX
  } op_mode_t;

  // Live state of the radio around this block
  typedef struct packed {
    op_mode_t opMode;
    logic oscRunning;
    logic pllLocked;
    logic strengthSampleStart;
    logic rxSettled;
    logic strengthValid;
    logic [7:0] strengthValue;
    logic bitTick;
    logic autoSequence;
    logic frameMatch;
    logic packetMode;
    logic [6:0] queueCount;
    logic [6:0] queueLevelLimit;
    logic queueOverflow;
    logic lastPayloadByte;
    logic crcOn;
    logic crcPass;
    logic keepBadPacket;
    logic supplyLow;
  } radio_status_t;

  // Requests back to the packet engine
  typedef struct packed {
    logic queueFlush;
    logic rxRestart;
  } queue_ctrl_t;

endpackage : rx_irq_pkg

// File: hdl/rx_timeout_timer.sv
// Receive timeout timer counting bit periods while armed.
// Assumes bitTick is a one-cycle pulse per bit period.
`timescale 1ns/1ps
`default_nettype none
module rx_timeout_timer #(
  parameter int SCALE = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic armed,
  input wire logic bitTick,
  input wire logic [7:0] limit,
  output logic expired
);
  localparam int CW = 13;
  logic [CW-1:0] count;
  logic [CW-1:0] target;
  logic done;

  if (SCALE < 1 || SCALE > 32) begin : g_chk
    $error("rx_timeout_timer: SCALE out of range");
  end

  assign target = CW'(limit) * CW'(SCALE);

  // Fires once per arming; zero limit never fires
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      done <= 1'b0;
      expired <= 1'b0;
    end else if (!armed) begin
      count <= '0;
      done <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (bitTick && !done && limit != 8'h00) begin
        count <= count + CW'(1);
        if (count + CW'(1) == target) begin
          done <= 1'b1;
          expired <= 1'b1;
        end
      end
    end
  end
endmodule : rx_timeout_timer
`default_nettype wire

// File: hdl/ref_clock_divider.sv
// Reference output divider and selector.
// Assumes rcClock is an already synchronous level from the RC oscillator.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_divider (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] sel,
  input wire logic rcClock,
  output logic refOut,
  output logic rcEnable
);
  logic [4:0] divCount;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divCount <= '0;
    end else begin
      divCount <= divCount + 5'h01;
    end
  end

  // Registered output: fastest setting toggles every cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      refOut <= 1'b0;
      rcEnable <= 1'b0;
    end else begin
      rcEnable <= (sel == rx_irq_pkg::REF_RC);
      if (sel == rx_irq_pkg::REF_OFF) begin
        refOut <= 1'b0;
      end else if (sel == rx_irq_pkg::REF_RC) begin
        refOut <= rcClock;
      end else if (sel == 3'h0) begin
        refOut <= ~refOut;
      end else begin
        refOut <= divCount[sel - 3'h1];
      end
    end
  end
endmodule : ref_clock_divider
`default_nettype wire

// File: hdl/rx_irq_flags_pin_map.sv
// Flag registers, thresholds, receive timeouts and pin routing of the receiver.
// Assumes an APB master on sys_clk and a radio status bundle synchronous to it.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rx_irq_flags_pin_map #(
  parameter int QUEUE_BYTES = rx_irq_pkg::QUEUE_BYTES,
  parameter int TIMEOUT_SCALE = rx_irq_pkg::TIMEOUT_SCALE
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rx_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rx_irq_pkg::radio_status_t radio,
  input wire logic rcClock,
  output rx_irq_pkg::queue_ctrl_t queueCtrl,
  output logic [rx_irq_pkg::NUM_PINS-1:0] eventPins,
  output logic refOutPin,
  output logic rcEnable
);

  if (QUEUE_BYTES < 1 || QUEUE_BYTES > 127) begin : g_chk
    $error("rx_irq_flags_pin_map: QUEUE_BYTES must fit the 7-bit count");
  end

  // ----------------------------------------
  // Address decode helper
  // ----------------------------------------
  function automatic logic [rx_irq_pkg::ADDR_W-1:0] regAddr(input logic [7:0] idx);
    regAddr = rx_irq_pkg::ADDR_W'(idx) << rx_irq_pkg::WORD_SHIFT;
  endfunction : regAddr

  // Pin source choice; packet and continuous sets differ
  function automatic logic routeSource(input logic [1:0] sel, input logic pkt,
                                       input logic [7:0] fa, input logic [7:0] fb);
    routeSource = 1'b0;
    if (pkt) begin
      case (sel)
        2'h0: routeSource = fb[rx_irq_pkg::BIT_PACKET_DONE];
        2'h1: routeSource = fa[rx_irq_pkg::BIT_MATCH];
        2'h2: routeSource = fb[rx_irq_pkg::BIT_LEVEL];
        default: routeSource = fa[rx_irq_pkg::BIT_TIMEOUT];
      endcase
    end else begin
      case (sel)
        2'h0: routeSource = fa[rx_irq_pkg::BIT_MATCH];
        2'h1: routeSource = fa[rx_irq_pkg::BIT_STRENGTH];
        2'h2: routeSource = fa[rx_irq_pkg::BIT_RX_READY];
        default: routeSource = fa[rx_irq_pkg::BIT_MODE_READY];
      endcase
    end
  endfunction : routeSource

  // ----------------------------------------
  // Registers and flags
  // ----------------------------------------
  logic [7:0] pinRouteA;
  logic [7:0] pinRouteB;
  logic [2:0] refOutSel;
  logic [7:0] strengthThreshold;
  logic [7:0] rxStartTimeout;
  logic [7:0] strengthToPayloadTimeout;
  logic modeReachedFlag;
  logic receiveSettledFlag;
  logic synthLockedFlag;
  logic strengthFlag;
  logic timeoutFlag;
  logic autoSequenceFlag;
  logic frameMatchFlag;
  logic queueOverflowFlag;
  logic packetDoneFlag;
  logic checksumGoodFlag;
  logic supplyLowFlag;
  logic strengthSeen;
  logic payloadSeen;
  logic [6:0] prevCount;
  rx_irq_pkg::op_mode_t prevMode;
  logic [7:0] flagsA;
  logic [7:0] flagsB;
  logic [7:0] readByte;
  logic mapped;
  logic wrStrobe;
  logic inRx;
  logic modeChange;
  logic queueEmptied;
  logic wrFlagsA;
  logic wrFlagsB;
  logic overflowClear;
  logic crcFail;
  logic entryExpired;
  logic postExpired;

  assign inRx = (radio.opMode == rx_irq_pkg::MODE_RX);
  assign modeChange = (radio.opMode != prevMode);
  assign queueEmptied = (prevCount != 7'h00) && (radio.queueCount == 7'h00);
  assign wrStrobe = psel && penable && pready && pwrite;
  assign wrFlagsA = wrStrobe && (paddr == regAddr(rx_irq_pkg::IDX_EVENT_FLAGS_A));
  assign wrFlagsB = wrStrobe && (paddr == regAddr(rx_irq_pkg::IDX_EVENT_FLAGS_B));
  assign overflowClear = wrFlagsB && pwdata[rx_irq_pkg::BIT_OVERRUN];
  assign crcFail = inRx && radio.lastPayloadByte && radio.crcOn && !radio.crcPass;

  always_comb begin
    flagsA = 8'h00;
    flagsA[rx_irq_pkg::BIT_MODE_READY] = modeReachedFlag;
    flagsA[rx_irq_pkg::BIT_RX_READY] = receiveSettledFlag;
    flagsA[rx_irq_pkg::BIT_LOCK] = synthLockedFlag;
    flagsA[rx_irq_pkg::BIT_STRENGTH] = strengthFlag;
    flagsA[rx_irq_pkg::BIT_TIMEOUT] = timeoutFlag;
    flagsA[rx_irq_pkg::BIT_AUTO] = autoSequenceFlag;
    flagsA[rx_irq_pkg::BIT_MATCH] = frameMatchFlag;
  end

  // Queue state flags are live views of the byte count
  always_comb begin
    flagsB = 8'h00;
    flagsB[rx_irq_pkg::BIT_FULL] = (radio.queueCount == 7'(QUEUE_BYTES));
    flagsB[rx_irq_pkg::BIT_NONEMPTY] = (radio.queueCount != 7'h00);
    flagsB[rx_irq_pkg::BIT_LEVEL] = (radio.queueCount > radio.queueLevelLimit);
    flagsB[rx_irq_pkg::BIT_OVERRUN] = queueOverflowFlag;
    flagsB[rx_irq_pkg::BIT_PACKET_DONE] = packetDoneFlag;
    flagsB[rx_irq_pkg::BIT_CRC_GOOD] = checksumGoodFlag;
    flagsB[rx_irq_pkg::BIT_SUPPLY_LOW] = supplyLowFlag;
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_comb begin
    readByte = 8'h00;
    mapped = 1'b1;
    if (paddr == regAddr(rx_irq_pkg::IDX_PIN_ROUTE_A)) begin
      readByte = pinRouteA;
    end else if (paddr == regAddr(rx_irq_pkg::IDX_PIN_ROUTE_B_CLOCK_OUT)) begin
      readByte = {pinRouteB[7:4], 1'b0, refOutSel};
    end else if (paddr == regAddr(rx_irq_pkg::IDX_EVENT_FLAGS_A)) begin
      readByte = flagsA;
    end else if (paddr == regAddr(rx_irq_pkg::IDX_EVENT_FLAGS_B)) begin
      readByte = flagsB;
    end else if (paddr == regAddr(rx_irq_pkg::IDX_STRENGTH_THRESHOLD)) begin
      readByte = strengthThreshold;
    end else if (paddr == regAddr(rx_irq_pkg::IDX_RX_START_TIMEOUT)) begin
      readByte = rxStartTimeout;
    end else if (paddr == regAddr(rx_irq_pkg::IDX_STRENGTH_TO_PAYLOAD_TIMEOUT)) begin
      readByte = strengthToPayloadTimeout;
    end else begin
      mapped = 1'b0;
    end
  end

  // Answer prepared in setup so every bus output is a flop; one access cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, readByte};
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinRouteA <= rx_irq_pkg::RST_ROUTE;
      pinRouteB <= rx_irq_pkg::RST_ROUTE;
      refOutSel <= rx_irq_pkg::REF_OFF;
      strengthThreshold <= rx_irq_pkg::RST_THRESHOLD;
      rxStartTimeout <= rx_irq_pkg::RST_TIMEOUT;
      strengthToPayloadTimeout <= rx_irq_pkg::RST_TIMEOUT;
    end else if (wrStrobe) begin
      if (paddr == regAddr(rx_irq_pkg::IDX_PIN_ROUTE_A)) begin
        pinRouteA <= pwdata[7:0];
      end else if (paddr == regAddr(rx_irq_pkg::IDX_PIN_ROUTE_B_CLOCK_OUT)) begin
        pinRouteB <= {pwdata[7:4], 4'h0};
        refOutSel <= pwdata[rx_irq_pkg::REF_SEL_LSB +: rx_irq_pkg::REF_SEL_W];
      end else if (paddr == regAddr(rx_irq_pkg::IDX_STRENGTH_THRESHOLD)) begin
        strengthThreshold <= pwdata[7:0];
      end else if (paddr == regAddr(rx_irq_pkg::IDX_RX_START_TIMEOUT)) begin
        rxStartTimeout <= pwdata[7:0];
      end else if (paddr == regAddr(rx_irq_pkg::IDX_STRENGTH_TO_PAYLOAD_TIMEOUT)) begin
        strengthToPayloadTimeout <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prevMode <= rx_irq_pkg::MODE_SLEEP;
      prevCount <= 7'h00;
    end else begin
      prevMode <= radio.opMode;
      prevCount <= radio.queueCount;
    end
  end

  // ----------------------------------------
  // Mode flags
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      modeReachedFlag <= 1'b1;
    end else if (modeChange) begin
      modeReachedFlag <= 1'b0;
    end else begin
      case (radio.opMode)
        rx_irq_pkg::MODE_SLEEP: modeReachedFlag <= 1'b1;
        rx_irq_pkg::MODE_STANDBY: if (radio.oscRunning) modeReachedFlag <= 1'b1;
        rx_irq_pkg::MODE_SYNTH: if (radio.pllLocked) modeReachedFlag <= 1'b1;
        rx_irq_pkg::MODE_RX: if (radio.strengthSampleStart) modeReachedFlag <= 1'b1;
        default: modeReachedFlag <= modeReachedFlag;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      receiveSettledFlag <= 1'b0;
      synthLockedFlag <= 1'b0;
      autoSequenceFlag <= 1'b0;
    end else begin
      if (!inRx) begin
        receiveSettledFlag <= 1'b0;
      end else if (radio.rxSettled) begin
        receiveSettledFlag <= 1'b1;
      end
      synthLockedFlag <= radio.pllLocked &&
                         (inRx || radio.opMode == rx_irq_pkg::MODE_SYNTH);
      autoSequenceFlag <= radio.autoSequence;
    end
  end

  // ----------------------------------------
  // Strength and timeouts
  // ----------------------------------------
  // Set beats a same-cycle software clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strengthFlag <= 1'b0;
    end else if (!inRx) begin
      strengthFlag <= 1'b0;
    end else if (radio.strengthValid && radio.strengthValue > strengthThreshold) begin
      strengthFlag <= 1'b1;
    end else if (wrFlagsA && pwdata[rx_irq_pkg::BIT_STRENGTH]) begin
      strengthFlag <= 1'b0;
    end
  end

  // Session latches so a software clear does not rearm the entry timer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strengthSeen <= 1'b0;
      payloadSeen <= 1'b0;
    end else if (!inRx) begin
      strengthSeen <= 1'b0;
      payloadSeen <= 1'b0;
    end else begin
      if (strengthFlag) strengthSeen <= 1'b1;
      if (packetDoneFlag) payloadSeen <= 1'b1;
    end
  end

  rx_timeout_timer #(.SCALE(TIMEOUT_SCALE)) u_entry_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .armed(inRx && !strengthSeen && !strengthFlag),
    .bitTick(radio.bitTick),
    .limit(rxStartTimeout),
    .expired(entryExpired)
  );

  rx_timeout_timer #(.SCALE(TIMEOUT_SCALE)) u_post_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .armed(inRx && strengthSeen && !payloadSeen && !packetDoneFlag),
    .bitTick(radio.bitTick),
    .limit(strengthToPayloadTimeout),
    .expired(postExpired)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      timeoutFlag <= 1'b0;
    end else if (inRx && (entryExpired || postExpired)) begin
      timeoutFlag <= 1'b1;
    end else if (!inRx || queueEmptied || overflowClear) begin
      timeoutFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frameMatchFlag <= 1'b0;
    end else if (inRx && radio.frameMatch) begin
      frameMatchFlag <= 1'b1;
    end else if (!inRx || queueEmptied || overflowClear) begin
      frameMatchFlag <= 1'b0;
    end else if (!radio.packetMode && wrFlagsA && pwdata[rx_irq_pkg::BIT_MATCH]) begin
      frameMatchFlag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Queue and packet flags
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      queueOverflowFlag <= 1'b0;
    end else if (radio.queueOverflow && radio.opMode != rx_irq_pkg::MODE_SLEEP) begin
      queueOverflowFlag <= 1'b1;
    end else if (overflowClear) begin
      queueOverflowFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      packetDoneFlag <= 1'b0;
      checksumGoodFlag <= 1'b0;
    end else begin
      if (inRx && radio.lastPayloadByte &&
          (!radio.crcOn || radio.keepBadPacket || radio.crcPass)) begin
        packetDoneFlag <= 1'b1;
      end else if (queueEmptied || overflowClear) begin
        packetDoneFlag <= 1'b0;
      end
      if (inRx && radio.lastPayloadByte && radio.crcOn && radio.crcPass) begin
        checksumGoodFlag <= 1'b1;
      end else if (queueEmptied || overflowClear) begin
        checksumGoodFlag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      supplyLowFlag <= 1'b0;
    end else if (radio.supplyLow) begin
      supplyLowFlag <= 1'b1;
    end else if (wrFlagsB && pwdata[rx_irq_pkg::BIT_SUPPLY_LOW]) begin
      supplyLowFlag <= 1'b0;
    end
  end

  // Flush after overflow clear or a dropped bad packet
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      queueCtrl <= '0;
    end else begin
      queueCtrl.queueFlush <= overflowClear || (crcFail && !radio.keepBadPacket);
      queueCtrl.rxRestart <= crcFail && !radio.keepBadPacket;
    end
  end

  // ----------------------------------------
  // Pin routing and reference output
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      eventPins <= '0;
    end else begin
      for (int p = 0; p < rx_irq_pkg::NUM_PINS; p++) begin
        if (p < 4) begin
          eventPins[p] <= routeSource(pinRouteA[7 - 2*p -: 2], radio.packetMode,
                                      flagsA, flagsB);
        end else begin
          eventPins[p] <= routeSource(pinRouteB[15 - 2*p -: 2], radio.packetMode,
                                      flagsA, flagsB);
        end
      end
    end
  end

  ref_clock_divider u_ref_div (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sel(refOutSel),
    .rcClock(rcClock),
    .refOut(refOutPin),
    .rcEnable(rcEnable)
  );

endmodule : rx_irq_flags_pin_map
`default_nettype wire

// File: verification/rx_irq_checker.sv
// Checker for the flag block: APB timing, queue flags, flush pulses.
// Assumes it is bound onto rx_irq_flags_pin_map.
`timescale 1ns/1ps
`default_nettype none
module rx_irq_checker #(
  parameter int QUEUE_BYTES = 66
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rx_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rx_irq_pkg::radio_status_t radio,
  input wire rx_irq_pkg::queue_ctrl_t queueCtrl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no access cycle after setup");
  chk_ready_only: assert property (pready |-> penable && $past(psel && !penable))
    else $error("ready without setup");
  chk_err_unmapped: assert property (psel && !penable && (paddr < 12'h094 || paddr > 12'h0AC)
    |=> pslverr)
    else $error("unmapped access not refused");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("unused read bits not zero");
  chk_overrun_flush: assert property (psel && penable && pready && pwrite && paddr == 12'h0A0
    && pwdata[4] |=> queueCtrl.queueFlush)
    else $error("overflow clear did not flush");
  chk_restart_flush: assert property (queueCtrl.rxRestart |-> queueCtrl.queueFlush)
    else $error("restart without flush");
  chk_full_nonempty: assert property (psel && !penable && !pwrite && paddr == 12'h0A0
    && $stable(radio.queueCount) |=> prdata[7] == ($past(radio.queueCount) == QUEUE_BYTES)
    && prdata[6] == ($past(radio.queueCount) != 7'h00))
    else $error("full or nonempty flag wrong");
  chk_level_limit: assert property (psel && !penable && !pwrite && paddr == 12'h0A0
    && $stable(radio.queueCount) && $stable(radio.queueLevelLimit)
    |=> prdata[5] == ($past(radio.queueCount) > $past(radio.queueLevelLimit)))
    else $error("level flag wrong");
endmodule : rx_irq_checker
bind rx_irq_flags_pin_map rx_irq_checker #(.QUEUE_BYTES(QUEUE_BYTES)) chk (.sys_clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .radio, .queueCtrl);
`default_nettype wire

// File: verification/radio_model.sv
// Far-side radio pieces: bit period tick and RC oscillator level.
// Assumes one bit period is four sys_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module radio_model (
  input wire logic sys_clk,
  input wire logic resetn,
  output logic bitTick,
  output logic rcClock
);
  logic [1:0] div;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end
  assign bitTick = (div == 2'h3);
  assign rcClock = div[1];
endmodule : radio_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for rx_irq_flags_pin_map over APB.
// Assumes radio_model for bit ticks and the package register map.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, tick, rcClock;
  logic refOutPin, rcEnable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] eventPins;
  rx_irq_pkg::radio_status_t st, radio;
  rx_irq_pkg::queue_ctrl_t queueCtrl;
  logic [16:0] expq[$];
  logic [16:0] e;
  logic [7:0] r;
  int num_errors, compares, nRestart;
  logic [7:0] rw[5] = '{8'h25, 8'h26, 8'h29, 8'h2A, 8'h2B};
  logic [7:0] rm[5] = '{8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF};
  rx_irq_flags_pin_map uut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .radio, .rcClock, .queueCtrl, .eventPins, .refOutPin, .rcEnable);
  radio_model far (.sys_clk, .resetn, .bitTick(tick), .rcClock);
  always_comb begin
    radio = st;
    radio.bitTick = tick;
  end
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] lf(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lf
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    // Look at pready mid-cycle so the next rising edge is the accepting one
    @(negedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 50) num_errors++;
    @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer
  task automatic rd(input logic [7:0] idx, d, m, input logic err = 1'b0);
    expq.push_back({err, d, m});
    xfer(1'b0, idx, 8'h00);
  endtask : rd
  // ----
  // Read monitor
  // ----
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
      e = expq.pop_front();
      check({pslverr, prdata & {24'hFFFFFF, e[7:0]}}, {e[16], 24'h0, e[15:8] & e[7:0]});
    end
    if (queueCtrl.rxRestart === 1'b1) nRestart++;
  end
  task automatic final_report;
    $display("compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (4000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, st} = '0;
    r = 8'h53;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(8'h25, 8'h00, 8'hFF);
    rd(8'h26, 8'h07, 8'hFF);
    rd(8'h27, 8'h80, 8'hFF);
    rd(8'h28, 8'h00, 8'hFF);
    rd(8'h29, 8'hE4, 8'hFF);
    rd(8'h2A, 8'h00, 8'hFF);
    rd(8'h2B, 8'h00, 8'hFF);
    rd(8'h2C, 8'h00, 8'hFF, 1'b1);
    $display("reset values done");
    foreach (rw[i]) begin
      r = lf(r);
      xfer(1'b1, rw[i], r);
      rd(rw[i], r & rm[i], 8'hFF);
    end
    xfer(1'b1, 8'h27, 8'hFF);
    rd(8'h27, 8'h80, 8'hFF);
    $display("register access done");
    st.queueLevelLimit <= 7'd10;
    foreach (rw[i]) begin
      st.queueCount <= (i == 0) ? 7'd66 : (i == 1) ? 7'd11 : (i == 2) ? 7'd10 : 7'd0;
      repeat (2) @(posedge sys_clk);
      rd(8'h28, (i == 0) ? 8'hE0 : (i == 1) ? 8'h60 : (i == 2) ? 8'h40 : 8'h00, 8'hE0);
    end
    $display("queue flags done");
    st.opMode <= rx_irq_pkg::MODE_RX;
    @(posedge sys_clk);
    st.queueOverflow <= 1'b1;
    st.supplyLow <= 1'b1;
    @(posedge sys_clk);
    st.queueOverflow <= 1'b0;
    st.supplyLow <= 1'b0;
    rd(8'h28, 8'h11, 8'h11);
    xfer(1'b1, 8'h28, 8'h00);
    rd(8'h28, 8'h11, 8'h11);
    xfer(1'b1, 8'h28, 8'h11);
    rd(8'h28, 8'h00, 8'h11);
    $display("sticky flags done");
    st.opMode <= rx_irq_pkg::MODE_STANDBY;
    xfer(1'b1, 8'h2A, 8'h01);
    st.opMode <= rx_irq_pkg::MODE_RX;
    repeat (40) @(posedge sys_clk);
    rd(8'h27, 8'h00, 8'h04);
    repeat (40) @(posedge sys_clk);
    rd(8'h27, 8'h04, 8'h04);
    st.opMode <= rx_irq_pkg::MODE_STANDBY;
    @(posedge sys_clk);
    rd(8'h27, 8'h00, 8'h04);
    $display("timeout done");
    {st.opMode, st.crcOn, st.lastPayloadByte} <= {rx_irq_pkg::MODE_RX, 2'b11};
    @(posedge sys_clk);
    st.lastPayloadByte <= 1'b0;
    rd(8'h28, 8'h00, 8'h04);
    check(33'(nRestart), 33'h1);
    {st.keepBadPacket, st.lastPayloadByte} <= 2'b11;
    @(posedge sys_clk);
    st.lastPayloadByte <= 1'b0;
    rd(8'h28, 8'h04, 8'h04);
    $display("bad checksum done");
    xfer(1'b1, 8'h26, 8'h06);
    repeat (3) @(posedge sys_clk);
    check({32'h0, rcEnable}, 33'h1);
    $display("reference select done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
